// ### lshto_lin_master.sv
// lin master model: drives break, sync, identifier and data frames onto the line
`timescale 1ns/1ps
module lshto_lin_master
  import lshto_pkg::*;
#(
  parameter int unsigned BIT_CLKS = 16
) (
  // clock
  input  wire logic i_clk,
  // lin line, idle high through the bus pull-up
  output logic      o_line
);
  // line rests recessive until the first frame
  initial o_line = 1'b1;

  // holds one level for n clocks, changing just after each edge
  task automatic hold(input logic v, input int unsigned n);
    repeat (n) begin
      @(posedge i_clk);
      o_line <= v;
    end
  endtask

  // start bit, eight data bits lsb first, then the given stop level
  task automatic send_byte(input logic [7:0] b, input logic stop);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT_CLKS);
    end
    hold(stop, BIT_CLKS);
  endtask

  // 13-bit break, delimiter, sync, idle gap given in samples, identifier
  task automatic send_header(input logic [7:0] id, input int unsigned gap);
    hold(1'b0, 13 * BIT_CLKS);
    hold(1'b1, BIT_CLKS);
    send_byte(SYNC_BYTE, 1'b1);
    hold(1'b1, gap * BIT_CLKS / SAMPLES_PER_BIT);
    send_byte(id, 1'b1);
  endtask
endmodule

// ### lshto_pkg.sv
// package: constants and types shared by the lin slave header time-out receiver
package lshto_pkg;

  // ************************************************************
  // sampling grid
  // ************************************************************
  localparam int unsigned SAMPLES_PER_BIT = 16;
  localparam int unsigned SAMP_W          = 4;
  localparam logic [3:0]  SAMP_MID        = 4'h7;   // last tick before mid-bit on start
  localparam logic [3:0]  SAMP_LAST       = 4'hf;   // tick of each data and stop sample
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam int unsigned DIV_W           = 16;

  // ************************************************************
  // header supervision
  // ************************************************************
  localparam int unsigned HDR_CNT_W           = 10;
  localparam int unsigned HDR_TIMEOUT_BITS    = 57;
  localparam logic [9:0]  HDR_TIMEOUT_SAMPLES = 10'(HDR_TIMEOUT_BITS * SAMPLES_PER_BIT);
  localparam logic [9:0]  HDR_BRK_PRESET      = 10'h098; // break seen at its stop sample
  localparam logic [7:0]  SYNC_BYTE           = 8'h55;
  localparam logic [7:0]  LEN_ON_TIMEOUT      = 8'h00;
  localparam logic [7:0]  BREAK_BYTE          = 8'h00;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic       MUTE_RST = 1'b1;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] LEN_RST  = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } lshto_rx_state_t;

  typedef enum logic [1:0] {
    HD_IDLE  = 2'b00,
    HD_SYNC  = 2'b01,
    HD_IDENT = 2'b10
  } lshto_hdr_state_t;

  typedef struct packed {
    logic header_error_flag;
    logic header_detected_flag;
    logic receive_full_flag;
    logic receiver_wakeup_mute_bit;
  } lshto_flags_t;

  localparam lshto_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, MUTE_RST};

endpackage

// ### lshto_receiver.sv
// receiver: lin slave byte reception with header supervision and mute control
`timescale 1ns/1ps
module lshto_receiver
  import lshto_pkg::*;
#(
  parameter int unsigned DIV_W = lshto_pkg::DIV_W
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // line and configuration
  input  wire logic                  i_line,
  input  wire logic [DIV_W-1:0]      i_sample_div,
  input  wire logic                  i_lin_slave_en,
  // software accesses, one-cycle pulses
  input  wire logic                  i_status_rd,
  input  wire logic                  i_data_rd,
  input  wire logic                  i_wakeup_set,
  // status and data
  output lshto_pkg::lshto_flags_t    o_flags,
  output logic [7:0]                 o_rx_data,
  output logic [7:0]                 o_header_length,
  output logic                       o_irq
);
  import lshto_pkg::*;

  logic                    line;
  logic                    tick;
  lshto_rx_state_t         rx_state_reg, rx_state_next;
  logic [SAMP_W-1:0]       samp_reg, samp_next;
  logic [2:0]              bit_reg, bit_next;
  logic [7:0]              shift_reg, shift_next;
  logic                    prev_reg, prev_next;
  logic                    byte_done;
  logic                    stop_ok;
  lshto_hdr_state_t        hd_state_reg, hd_state_next;
  logic [HDR_CNT_W-1:0]    hcnt_reg, hcnt_next;
  logic                    hdr_timeout;
  logic                    hdr_ok;
  logic                    hdr_bad;
  lshto_flags_t            flags_reg, flags_next;
  logic [7:0]              data_reg, data_next;
  logic [7:0]              len_reg, len_next;
  logic                    armed_reg, armed_next;
  logic                    irq_reg, irq_next;
  logic                    clr;

  // ************************************************************
  // line synchroniser and sample tick
  // ************************************************************
  lshto_sampler #(
    .DIV_W (DIV_W)
  ) u_sampler (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_div       (i_sample_div),
    .i_line      (i_line),
    .o_line_sync (line),
    .o_tick      (tick)
  );

  // ************************************************************
  // byte reception on the sixteen-per-bit grid
  // ************************************************************
  always_comb begin
    rx_state_next = rx_state_reg;
    samp_next     = samp_reg;
    bit_next      = bit_reg;
    shift_next    = shift_reg;
    prev_next     = tick ? line : prev_reg;
    byte_done     = 1'b0;
    stop_ok       = 1'b0;
    if (tick) begin
      samp_next = samp_reg + 1'b1;
      case (rx_state_reg)
        RX_IDLE: begin
          samp_next = '0;
          if (prev_reg && !line) begin // falling edge opens a start bit
            rx_state_next = RX_START;
          end
        end
        RX_START: begin
          if (samp_reg == SAMP_MID) begin
            samp_next     = '0;
            bit_next      = '0;
            rx_state_next = line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (samp_reg == SAMP_LAST) begin
            shift_next = {line, shift_reg[7:1]};
            bit_next   = bit_reg + 1'b1;
            if (bit_reg == BIT_LAST) begin
              rx_state_next = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (samp_reg == SAMP_LAST) begin
            byte_done     = 1'b1;
            stop_ok       = line;
            rx_state_next = RX_IDLE;
          end
        end
        default: rx_state_next = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_reg <= RX_IDLE;
      samp_reg     <= '0;
      bit_reg      <= '0;
      shift_reg    <= '0;
      prev_reg     <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      samp_reg     <= samp_next;
      bit_reg      <= bit_next;
      shift_reg    <= shift_next;
      prev_reg     <= prev_next;
    end
  end

  // ************************************************************
  // header supervision: break, sync field, identifier, time-out
  // ************************************************************
  always_comb begin
    hd_state_next = hd_state_reg;
    hcnt_next     = hcnt_reg;
    hdr_timeout   = 1'b0;
    hdr_ok        = 1'b0;
    hdr_bad       = 1'b0;
    case (hd_state_reg)
      HD_IDLE: begin
        if (i_lin_slave_en && byte_done && !stop_ok && shift_next == BREAK_BYTE) begin
          hd_state_next = HD_SYNC;
          hcnt_next     = HDR_BRK_PRESET;
        end
      end
      HD_SYNC, HD_IDENT: begin
        if (tick && hcnt_reg < HDR_TIMEOUT_SAMPLES) begin
          hcnt_next = hcnt_reg + 1'b1;
        end
        if (tick && hcnt_reg >= HDR_TIMEOUT_SAMPLES) begin
          hdr_timeout   = 1'b1; // time-out wins over a stop bit in the same tick
          hd_state_next = HD_IDLE;
        end else if (byte_done) begin
          if (hd_state_reg == HD_SYNC && stop_ok && shift_next == SYNC_BYTE) begin
            hd_state_next = HD_IDENT;
          end else if (hd_state_reg == HD_IDENT && stop_ok) begin
            hdr_ok        = 1'b1;
            hd_state_next = HD_IDLE;
          end else begin
            hdr_bad       = 1'b1;
            hd_state_next = HD_IDLE;
          end
        end
      end
      default: hd_state_next = HD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hd_state_reg <= HD_IDLE;
      hcnt_reg     <= '0;
    end else begin
      hd_state_reg <= hd_state_next;
      hcnt_reg     <= hcnt_next;
    end
  end

  // ************************************************************
  // flags, data, length and interrupt
  // ************************************************************
  always_comb begin
    clr        = armed_reg && i_data_rd;
    armed_next = i_status_rd ? 1'b1 : (i_data_rd ? 1'b0 : armed_reg);
    flags_next = flags_reg;
    data_next  = data_reg;
    len_next   = len_reg;
    // software clear first, hardware set afterwards so a set wins
    if (clr) begin
      flags_next.header_error_flag    = 1'b0;
      flags_next.header_detected_flag = 1'b0;
      flags_next.receive_full_flag    = 1'b0;
    end
    if (i_wakeup_set) begin
      flags_next.receiver_wakeup_mute_bit = 1'b1;
    end
    if (hdr_timeout) begin
      flags_next.header_error_flag        = 1'b1;
      flags_next.header_detected_flag     = 1'b0;
      flags_next.receiver_wakeup_mute_bit = 1'b1;
      len_next                            = LEN_ON_TIMEOUT;
    end
    if (hdr_bad) begin
      flags_next.header_error_flag = 1'b1;
      len_next                     = 8'(hcnt_reg >> 4);
    end
    if (hdr_ok) begin
      flags_next.header_detected_flag     = 1'b1;
      flags_next.receiver_wakeup_mute_bit = i_wakeup_set;
      len_next                            = 8'(hcnt_reg >> 4);
      data_next                           = shift_next;
    end
    if (byte_done && stop_ok && hd_state_reg == HD_IDLE && !flags_reg.receiver_wakeup_mute_bit) begin
      flags_next.receive_full_flag = 1'b1;
      data_next                    = shift_next;
    end
    irq_next = flags_next.header_error_flag | flags_next.header_detected_flag
             | flags_next.receive_full_flag;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_reg <= FLAGS_RST;
      data_reg  <= DATA_RST;
      len_reg   <= LEN_RST;
      armed_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      data_reg  <= data_next;
      len_reg   <= len_next;
      armed_reg <= armed_next;
      irq_reg   <= irq_next;
    end
  end

  assign o_flags         = flags_reg;
  assign o_rx_data       = data_reg;
  assign o_header_length = len_reg;
  assign o_irq           = irq_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_timeout_count: assert property (
    hdr_timeout |-> hcnt_reg == HDR_TIMEOUT_SAMPLES && hd_state_reg != HD_IDLE
  ) else $error("time-out at wrong header length");

  a_timeout_error: assert property (
    hdr_timeout |=> flags_reg.header_error_flag
  ) else $error("time-out did not set header error");

  a_timeout_mute_irq: assert property (
    hdr_timeout |=> flags_reg.receiver_wakeup_mute_bit && irq_reg
  ) else $error("time-out left mute or gave no interrupt");

  a_stop_sample_pos: assert property (
    byte_done |-> samp_reg == SAMP_LAST && rx_state_reg == RX_STOP && $past(tick, 16) == 1'b1
  ) else $error("stop bit sampled off grid");

  a_timeout_no_detect: assert property (
    hdr_timeout |=> !flags_reg.header_detected_flag
  ) else $error("header detected set on time-out");

  a_timeout_len_zero: assert property (
    hdr_timeout |=> len_reg == 8'h00
  ) else $error("header length not zero on time-out");

  a_two_read_clear: assert property (
    i_status_rd ##1 (!i_status_rd && i_data_rd && !hdr_timeout && !hdr_bad)[*1] |=> !flags_reg.header_error_flag
  ) else $error("two-read sequence did not clear header error");

  a_data_sets_full: assert property (
    byte_done && stop_ok && hd_state_reg == HD_IDLE && !flags_reg.receiver_wakeup_mute_bit
      |=> flags_reg.receive_full_flag && irq_reg && data_reg == $past(shift_next)
  ) else $error("data byte lost while awake");

  a_wakeup_set_mutes: assert property (
    i_wakeup_set |=> flags_reg.receiver_wakeup_mute_bit
  ) else $error("mute bit not set by software");

  a_wake_only_header: assert property (
    $fell(flags_reg.receiver_wakeup_mute_bit) |-> $past(hdr_ok) && !$past(hdr_timeout)
  ) else $error("left mute without a valid header");

endmodule

// ### lshto_receiver_test.sv
// testbench: header supervision, wake, mute and flag clearing of the lin slave receiver
`timescale 1ns/1ps
module lshto_receiver_test;
  import lshto_pkg::*;
  typedef struct packed {
    lshto_flags_t f;
    logic [7:0]   d;
    logic [7:0]   l;
    logic         irq;
  } lshto_obs_t;
  localparam int unsigned DIV      = 0;
  localparam int unsigned BIT_CLKS = SAMPLES_PER_BIT * (DIV + 1);
  logic             i_clk;
  logic             i_rst;
  logic             i_line;
  logic [DIV_W-1:0] i_sample_div;
  logic             i_lin_slave_en;
  logic             i_status_rd;
  logic             i_data_rd;
  logic             i_wakeup_set;
  lshto_flags_t     o_flags;
  logic [7:0]       o_rx_data;
  logic [7:0]       o_header_length;
  logic             o_irq;
  lshto_obs_t       cur;
  lshto_obs_t       prv;
  lshto_obs_t       exp_v;
  lshto_obs_t       exp_q[$];
  int               err_count;
  int               n_checks;
  integer           seed;
  logic [7:0]       id_v;
  logic [7:0]       dat_v;

  lshto_receiver #(.DIV_W(DIV_W)) lshto_receiver_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_line(i_line), .i_sample_div(i_sample_div),
    .i_lin_slave_en(i_lin_slave_en), .i_status_rd(i_status_rd), .i_data_rd(i_data_rd),
    .i_wakeup_set(i_wakeup_set), .o_flags(o_flags), .o_rx_data(o_rx_data),
    .o_header_length(o_header_length), .o_irq(o_irq));
  lshto_lin_master #(.BIT_CLKS(BIT_CLKS)) lshto_lin_master_inst (.i_clk(i_clk), .o_line(i_line));

  assign cur = {o_flags, o_rx_data, o_header_length, o_irq};

  // 25 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ************************************************************
  // comparison and reporting
  // ************************************************************
  task automatic check(input lshto_obs_t seen, input lshto_obs_t want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t ns seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // records an expected output change
  task automatic note(input lshto_obs_t v);
    exp_v = v;
    exp_q.push_back(v);
  endtask

  // bounded wait until the watcher has consumed every note
  task automatic settle;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) begin
      @(posedge i_clk);
    end
    if (exp_q.size() != 0) begin
      err_count++;
      $display("timeout at %0t ns waiting for an output change", $time);
      test_done();
    end
  endtask

  // waits eight quiet cycles, then a falling edge, so the watcher can catch any stray output change
  task automatic quiet;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // status read then data read on the next cycle
  task automatic sw_clear;
    @(posedge i_clk);
    i_status_rd <= 1'b1;
    @(posedge i_clk);
    i_status_rd <= 1'b0;
    i_data_rd   <= 1'b1;
    @(posedge i_clk);
    i_data_rd   <= 1'b0;
  endtask

  // single-cycle software pulses
  task automatic pulse_data_rd;
    @(posedge i_clk);
    i_data_rd <= 1'b1;
    @(posedge i_clk);
    i_data_rd <= 1'b0;
  endtask

  task automatic wake_set;
    @(posedge i_clk);
    i_wakeup_set <= 1'b1;
    @(posedge i_clk);
    i_wakeup_set <= 1'b0;
  endtask

  // watcher: every output change must match the oldest note, otherwise none may occur
  always @(negedge i_clk) begin
    if (i_rst) begin
      prv = cur;
    end else if (cur !== prv) begin
      if (exp_q.size() > 0) begin
        check(cur, exp_q.pop_front());
      end else begin
        check(cur, prv);
      end
      prv = cur;
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 79;
    err_count = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_sample_div = DIV_W'(DIV);
    i_lin_slave_en = 1'b1;
    i_status_rd = 1'b0;
    i_data_rd = 1'b0;
    i_wakeup_set = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    exp_v = {FLAGS_RST, DATA_RST, LEN_RST, 1'b0};
    check(cur, exp_v);
    $display("test reset done");
    // valid header from mute, length 33 bits on the sixteen-sample grid
    id_v = 8'($random(seed));
    note({4'b0100, id_v, 8'h21, 1'b1});
    lshto_lin_master_inst.send_header(id_v, 0);
    settle();
    $display("test header done");
    // awake: each byte sets full; a lone data read does not clear
    repeat (2) begin
      dat_v = 8'($random(seed));
      note({exp_v.f | 4'b0010, dat_v, exp_v.l, 1'b1});
      lshto_lin_master_inst.send_byte(dat_v, 1'b1);
      settle();
      pulse_data_rd();
      quiet();
      check(cur, exp_v);
      note({4'b0000, dat_v, exp_v.l, 1'b0});
      sw_clear();
      settle();
    end
    $display("test data done");
    // software mute, then bytes are ignored
    note({4'b0001, exp_v.d, exp_v.l, 1'b0});
    wake_set();
    settle();
    lshto_lin_master_inst.send_byte(8'($random(seed)), 1'b1);
    quiet();
    check(cur, exp_v);
    $display("test mute done");
    // long header, eight samples short of the time-out, still valid: identifier stop near 56 bits
    id_v = 8'($random(seed));
    note({4'b0100, id_v, 8'h38, 1'b1});
    lshto_lin_master_inst.send_header(id_v, 369);
    settle();
    note({4'b0000, id_v, 8'h38, 1'b0});
    sw_clear();
    settle();
    note({4'b0001, id_v, 8'h38, 1'b0});
    wake_set();
    settle();
    $display("test boundary done");
    // time-out inside the identifier stop bit: error, no detect, zero length, stay muted
    note({4'b1001, id_v, LEN_ON_TIMEOUT, 1'b1});
    lshto_lin_master_inst.send_header(8'($random(seed)), 379);
    settle();
    lshto_lin_master_inst.send_byte(8'($random(seed)), 1'b1);
    quiet();
    check(cur, exp_v);
    note({4'b0001, id_v, LEN_ON_TIMEOUT, 1'b0});
    sw_clear();
    settle();
    $display("test timeout done");
    // time-out on the very tick of the identifier stop sample: time-out wins, stay muted
    note({4'b1001, exp_v.d, LEN_ON_TIMEOUT, 1'b1});
    lshto_lin_master_inst.send_header(8'($random(seed)), 377);
    settle();
    note({4'b0001, exp_v.d, LEN_ON_TIMEOUT, 1'b0});
    sw_clear();
    settle();
    $display("test tie done");
    // header detection disabled: a muted receiver ignores a whole header
    @(posedge i_clk);
    i_lin_slave_en <= 1'b0;
    lshto_lin_master_inst.send_header(8'($random(seed)), 0);
    quiet();
    check(cur, exp_v);
    @(posedge i_clk);
    i_lin_slave_en <= 1'b1;
    $display("test disabled done");
    test_done();
  end
endmodule

// ### lshto_sampler.sv
// sampler: line synchroniser and sixteen-per-bit sample tick generator
`timescale 1ns/1ps
module lshto_sampler #(
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // configuration and line
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_line,
  // sampled outputs
  output logic                  o_line_sync,
  output logic                  o_tick
);

  logic             meta_reg;
  logic             sync_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  // ************************************************************
  // next values: divider wraps at i_div, tick marks the wrap
  // ************************************************************
  always_comb begin
    tick_next = (cnt_reg >= i_div);
    cnt_next  = tick_next ? '0 : cnt_reg + 1'b1;
  end

  // two flip-flops before the line is used, idle line is high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      meta_reg <= i_line;
      sync_reg <= meta_reg;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_line_sync = sync_reg;
  assign o_tick      = tick_reg;

endmodule
